// ===== design/cfg_field_store.sv
// holding register for the ten configuration bits
`timescale 1ns/1ps
`default_nettype none
module cfg_field_store (
  input  wire logic        clk_i,
  input  wire logic        rst_b_i,
  input  wire logic        we_i,
  input  wire logic [9:0]  wdata_i,
  output logic      [9:0]  rdata_o
);
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rdata_o <= cfg_primary_pkg::CFG_RESET[9:0];
    end else if (we_i) begin
      rdata_o <= wdata_i;
    end
  end
endmodule
`default_nettype wire

// ===== design/cfg_primary_pkg.sv
// constants and types for the primary configuration register
`default_nettype none
package cfg_primary_pkg;
  localparam logic [2:0]  CFG_INDEX       = 3'h1;
  localparam logic [15:0] CFG_RESET       = 16'h0000;
  localparam int          WR_BIT          = 15;
  localparam int          IDX_HI          = 14;
  localparam int          IDX_LO          = 12;
  localparam int          STYLE_BIT       = 9;
  localparam int          RATIO_HI        = 8;
  localparam int          RATIO_LO        = 6;
  localparam int          CRC_IN_BIT      = 5;
  localparam int          CRC_OUT_BIT     = 4;
  localparam int          ALERT_BIT       = 3;
  localparam int          PREC_BIT        = 2;
  localparam int          REF_BIT         = 1;
  localparam int          SHDN_BIT        = 0;
  localparam logic [1:0]  LANES_SINGLE    = 2'h1;
  localparam logic [2:0]  RATIO_MAX       = 3'h5;
  localparam logic [2:0]  RATIO_ROLL_MAX  = 3'h3;
  localparam logic [11:0] DATA_MASK       = 12'h3FF;

  typedef struct packed {
    logic       averaging_style;
    logic [2:0] oversample_ratio;
    logic       crc_in_en;
    logic       crc_out_en;
    logic       alert_select;
    logic       extra_precision;
    logic       reference_source;
    logic       shutdown_select;
  } cfg_fields_type;

  typedef struct packed {
    logic       valid;
    logic       crc_ok;
    logic [15:0] word;
  } frame_type;
endpackage
`default_nettype wire

// ===== design/cfg_primary_reg.sv
// primary configuration register with decoded control outputs
`timescale 1ns/1ps
`default_nettype none
module cfg_primary_reg (
  input  wire logic                       CLK_I,
  input  wire logic                       RST_B_I,
  input  wire cfg_primary_pkg::frame_type FRAME_I,
  input  wire logic [1:0]                 OUTPUT_LANE_COUNT_I,
  output logic [15:0]                     READ_WORD_O,
  output logic                            AVERAGING_STYLE_O,
  output logic [2:0]                      OVERSAMPLE_RATIO_O,
  output logic                            OVERSAMPLE_ON_O,
  output logic [5:0]                      RATIO_LOG2_O,
  output logic                            RATIO_ILLEGAL_O,
  output logic                            CRC_IN_EN_O,
  output logic                            CRC_OUT_EN_O,
  output logic                            ALERT_PIN_MODE_O,
  output logic                            WIDE_RESULT_O,
  output logic                            REFERENCE_SOURCE_O,
  output logic                            SHUTDOWN_SELECT_O
);
  logic [9:0] stored;
  logic [9:0] new_bits;
  logic       hit;
  logic       crc_bit_change;
  logic       crc_gate_ok;
  logic       we;
  logic [2:0] r_d;
  logic       on_d;
  logic       bad_d;
  logic [5:0] log_d;
  logic       wide_d;
  logic       alert_d;

  // ratio codes 1..5 are active, all others disable oversampling
  function automatic logic ratio_active(input logic [2:0] r);
    ratio_active = (r != 3'h0) && (r <= cfg_primary_pkg::RATIO_MAX);
  endfunction

  assign hit = FRAME_I.valid && FRAME_I.word[cfg_primary_pkg::WR_BIT]
             && (FRAME_I.word[cfg_primary_pkg::IDX_HI:cfg_primary_pkg::IDX_LO]
                 == cfg_primary_pkg::CFG_INDEX);
  assign new_bits = FRAME_I.word[9:0];
  assign crc_bit_change = new_bits[cfg_primary_pkg::CRC_IN_BIT] != stored[cfg_primary_pkg::CRC_IN_BIT];
  // toggling the input-crc bit, either way, needs a good crc or the frame is dropped
  assign crc_gate_ok = !crc_bit_change || FRAME_I.crc_ok;
  assign we = hit && crc_gate_ok;

  cfg_field_store u_store (
    .clk_i   (CLK_I),
    .rst_b_i (RST_B_I),
    .we_i    (we),
    .wdata_i (new_bits),
    .rdata_o (stored)
  );

  assign r_d   = stored[cfg_primary_pkg::RATIO_HI:cfg_primary_pkg::RATIO_LO];
  assign on_d  = ratio_active(r_d);
  assign log_d = on_d ? {3'h0, r_d} : 6'h00;
  // rolling mode only covers 2x..8x; flag the undefined pairing
  assign bad_d = stored[cfg_primary_pkg::STYLE_BIT] && on_d
               && (r_d > cfg_primary_pkg::RATIO_ROLL_MAX);
  assign wide_d  = stored[cfg_primary_pkg::PREC_BIT] && on_d;
  assign alert_d = stored[cfg_primary_pkg::ALERT_BIT]
                 && (OUTPUT_LANE_COUNT_I == cfg_primary_pkg::LANES_SINGLE);

  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      READ_WORD_O        <= 16'h0000;
      AVERAGING_STYLE_O  <= 1'b0;
      OVERSAMPLE_RATIO_O <= 3'h0;
      OVERSAMPLE_ON_O    <= 1'b0;
      RATIO_LOG2_O       <= 6'h00;
      RATIO_ILLEGAL_O    <= 1'b0;
      CRC_IN_EN_O        <= 1'b0;
      CRC_OUT_EN_O       <= 1'b0;
      ALERT_PIN_MODE_O   <= 1'b0;
      WIDE_RESULT_O      <= 1'b0;
      REFERENCE_SOURCE_O <= 1'b0;
      SHUTDOWN_SELECT_O  <= 1'b0;
    end else begin
      READ_WORD_O        <= {1'b0, cfg_primary_pkg::CFG_INDEX, 2'h0, stored};
      AVERAGING_STYLE_O  <= stored[cfg_primary_pkg::STYLE_BIT];
      OVERSAMPLE_RATIO_O <= r_d;
      OVERSAMPLE_ON_O    <= on_d;
      RATIO_LOG2_O       <= log_d;
      RATIO_ILLEGAL_O    <= bad_d;
      CRC_IN_EN_O        <= stored[cfg_primary_pkg::CRC_IN_BIT];
      CRC_OUT_EN_O       <= stored[cfg_primary_pkg::CRC_OUT_BIT];
      ALERT_PIN_MODE_O   <= alert_d;
      WIDE_RESULT_O      <= wide_d;
      REFERENCE_SOURCE_O <= stored[cfg_primary_pkg::REF_BIT];
      SHUTDOWN_SELECT_O  <= stored[cfg_primary_pkg::SHDN_BIT];
    end
  end

  // a frame that the register takes: write flag, own index, crc gate passed
  sequence s_write_hit;
    hit && crc_gate_ok;
  endsequence

  // the taken bits stand in the read word two edges after the frame
  sequence s_read_shows_write;
    ##2 (READ_WORD_O[9:0] == $past(new_bits, 2));
  endsequence

  // raising the input-crc bit without and with a good crc
  sequence s_crc_raise_bad;
    hit && !FRAME_I.crc_ok && !stored[cfg_primary_pkg::CRC_IN_BIT]
    && new_bits[cfg_primary_pkg::CRC_IN_BIT];
  endsequence

  sequence s_crc_raise_good;
    hit && FRAME_I.crc_ok && new_bits[cfg_primary_pkg::CRC_IN_BIT];
  endsequence

  // dropping the input-crc bit without and with a good crc
  sequence s_crc_drop_bad;
    hit && !FRAME_I.crc_ok && stored[cfg_primary_pkg::CRC_IN_BIT]
    && !new_bits[cfg_primary_pkg::CRC_IN_BIT];
  endsequence

  sequence s_crc_drop_good;
    hit && FRAME_I.crc_ok && !new_bits[cfg_primary_pkg::CRC_IN_BIT];
  endsequence

  // a write that leaves the input-crc bit alone needs no crc
  sequence s_crc_untouched;
    hit && !crc_bit_change;
  endsequence

  // frames that must leave the register alone
  sequence s_foreign_frame;
    FRAME_I.valid
    && (FRAME_I.word[cfg_primary_pkg::IDX_HI:cfg_primary_pkg::IDX_LO] != cfg_primary_pkg::CFG_INDEX);
  endsequence

  sequence s_read_frame;
    FRAME_I.valid && !FRAME_I.word[cfg_primary_pkg::WR_BIT];
  endsequence

  a_write_loads: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    s_write_hit |-> s_read_shows_write)
    else $error("accepted write did not reach read word");

  a_crc_set_guard: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    s_crc_raise_bad |=> (stored == $past(stored)))
    else $error("input crc set without valid crc");

  a_crc_set_taken: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    s_crc_raise_good |=> stored[cfg_primary_pkg::CRC_IN_BIT])
    else $error("input crc not set by checked frame");

  a_crc_clr_guard: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    s_crc_drop_bad |=> (stored == $past(stored)))
    else $error("input crc cleared without valid crc");

  a_crc_clr_taken: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    s_crc_drop_good |=> !stored[cfg_primary_pkg::CRC_IN_BIT])
    else $error("input crc not cleared by checked frame");

  a_crc_free_write: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    s_crc_untouched |=> (stored == $past(new_bits)))
    else $error("write without crc change was not taken");

  a_index_only: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    s_foreign_frame |=> $stable(stored))
    else $error("write to other index changed register");

  a_read_no_write: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    s_read_frame |=> $stable(stored))
    else $error("read frame changed register");

  a_index_field: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    $past(RST_B_I) |-> (READ_WORD_O[cfg_primary_pkg::WR_BIT:cfg_primary_pkg::IDX_LO] == {1'b0, cfg_primary_pkg::CFG_INDEX}))
    else $error("read word index field wrong");

  a_style_follows: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    AVERAGING_STYLE_O == READ_WORD_O[cfg_primary_pkg::STYLE_BIT])
    else $error("averaging style differs from register");

  a_ratio_follows: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    OVERSAMPLE_RATIO_O == READ_WORD_O[cfg_primary_pkg::RATIO_HI:cfg_primary_pkg::RATIO_LO])
    else $error("ratio output differs from register");

  a_ratio_on: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    OVERSAMPLE_ON_O == ((OVERSAMPLE_RATIO_O != 3'h0) && (OVERSAMPLE_RATIO_O <= cfg_primary_pkg::RATIO_MAX)))
    else $error("oversampling enable wrong for ratio");

  a_ratio_log: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    OVERSAMPLE_ON_O |-> (RATIO_LOG2_O == {3'h0, OVERSAMPLE_RATIO_O}))
    else $error("ratio log mismatch");

  a_ratio_off_log: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    !OVERSAMPLE_ON_O |-> (RATIO_LOG2_O == 6'h00))
    else $error("ratio log not zero while disabled");

  a_roll_flag: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    (AVERAGING_STYLE_O && OVERSAMPLE_RATIO_O inside {3'h4, 3'h5}) |-> RATIO_ILLEGAL_O)
    else $error("rolling ratio not flagged");

  a_roll_only: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    RATIO_ILLEGAL_O |-> (AVERAGING_STYLE_O && OVERSAMPLE_ON_O && (OVERSAMPLE_RATIO_O > cfg_primary_pkg::RATIO_ROLL_MAX)))
    else $error("ratio flagged without rolling overrange");

  a_crc_in_follows: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    CRC_IN_EN_O == READ_WORD_O[cfg_primary_pkg::CRC_IN_BIT])
    else $error("input crc enable differs from register");

  a_crc_out_follows: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    CRC_OUT_EN_O == READ_WORD_O[cfg_primary_pkg::CRC_OUT_BIT])
    else $error("output crc enable differs from register");

  a_alert_lanes: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    ALERT_PIN_MODE_O |-> ($past(OUTPUT_LANE_COUNT_I) == cfg_primary_pkg::LANES_SINGLE))
    else $error("alert mode without single lane");

  a_alert_needs_bit: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    ALERT_PIN_MODE_O |-> $past(stored[cfg_primary_pkg::ALERT_BIT]))
    else $error("alert mode without select bit");

  a_alert_single: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    ($past(stored[cfg_primary_pkg::ALERT_BIT]) && ($past(OUTPUT_LANE_COUNT_I) == cfg_primary_pkg::LANES_SINGLE))
    |-> ALERT_PIN_MODE_O)
    else $error("alert mode missing with single lane");

  a_wide_gated: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    WIDE_RESULT_O |-> (OVERSAMPLE_RATIO_O != 3'h0 && OVERSAMPLE_RATIO_O <= cfg_primary_pkg::RATIO_MAX))
    else $error("wide result with oversampling off");

  a_wide_follows: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    (OVERSAMPLE_ON_O && READ_WORD_O[cfg_primary_pkg::PREC_BIT]) |-> WIDE_RESULT_O)
    else $error("wide result missing with precision bit");

  a_wide_needs_bit: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    WIDE_RESULT_O |-> READ_WORD_O[cfg_primary_pkg::PREC_BIT])
    else $error("wide result without precision bit");

  a_ref_follows: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    REFERENCE_SOURCE_O == READ_WORD_O[cfg_primary_pkg::REF_BIT])
    else $error("reference source differs from register");

  a_shutdown_bit: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    SHUTDOWN_SELECT_O == READ_WORD_O[cfg_primary_pkg::SHDN_BIT])
    else $error("shutdown output differs from register");
endmodule
`default_nettype wire

// ===== dv/adc_primary_config_register_tb_top.sv
// self-checking bench for the primary configuration register
`timescale 1ns/1ps
`default_nettype none
module adc_primary_config_register_tb_top;
  logic clk = 1'b0, rst_b = 1'b0, style, on, ill, cin, cout, alert, wide, refs, shdn;
  logic [1:0] lanes = 2'h0;
  logic [2:0] ratio;
  logic [5:0] lg;
  logic [15:0] rd;
  int n_errors = 0, checked = 0;
  cfg_primary_pkg::frame_type frame;
  always #20 clk = ~clk;
  host_frame_model host (.clk_i(clk), .frame_o(frame));
  cfg_primary_reg uut (.CLK_I(clk), .RST_B_I(rst_b), .FRAME_I(frame), .OUTPUT_LANE_COUNT_I(lanes),
    .READ_WORD_O(rd), .AVERAGING_STYLE_O(style), .OVERSAMPLE_RATIO_O(ratio), .OVERSAMPLE_ON_O(on),
    .RATIO_LOG2_O(lg), .RATIO_ILLEGAL_O(ill), .CRC_IN_EN_O(cin), .CRC_OUT_EN_O(cout),
    .ALERT_PIN_MODE_O(alert), .WIDE_RESULT_O(wide), .REFERENCE_SOURCE_O(refs), .SHUTDOWN_SELECT_O(shdn));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // frame then the two fixed cycles until outputs follow
  task automatic wr(input logic [15:0] w, input logic ok);
    host.send(w, ok);
    repeat (2) @(negedge clk);
  endtask
  task automatic t_walk();
    wr(16'h9245, 1'b0);
    chk(rd, 16'h1245);
    chk({style, ratio, on, wide, shdn}, 16'h004F);
    chk({refs, cin, cout, ill}, 16'h0000);
  endtask
  task automatic t_ratio();
    for (int r = 0; r < 8; r++) begin
      wr(16'h9006 | 16'(r << 6), 1'b0);
      chk(on, 16'(r inside {[1:5]}));
      chk(lg, (r inside {[1:5]}) ? 16'(r) : 16'h0000);
      chk({style, wide, refs}, {14'h0000, r inside {[1:5]}, 1'b1});
    end
  endtask
  task automatic t_roll();
    wr(16'h92C0, 1'b0);
    chk({style, ill}, 16'h0002);
    wr(16'h9300, 1'b0);
    chk({ill, ratio}, 16'h000C);
  endtask
  task automatic t_crc();
    wr(16'h9030, 1'b0);
    chk(rd, 16'h1300);
    wr(16'h9030, 1'b1);
    chk({cin, cout}, 16'h0003);
    wr(16'h9010, 1'b0);
    chk(cin, 16'h0001);
    wr(16'h9010, 1'b1);
    chk(rd, 16'h1010);
    wr(16'hA3FF, 1'b1);
    wr(16'h13FF, 1'b1);
    chk(rd, 16'h1010);
  endtask
  task automatic t_alert();
    wr(16'h9008, 1'b0);
    for (int l = 0; l < 4; l++) begin
      lanes = 2'(l);
      repeat (2) @(negedge clk);
      chk(alert, 16'(l == 1));
    end
  endtask
  // mid-run reset with the alert function active, then release
  task automatic t_reset();
    lanes = 2'h1;
    repeat (2) @(negedge clk);
    chk(alert, 16'h0001);
    rst_b = 1'b0;
    @(negedge clk);
    chk(rd, 16'h0000);
    chk({style, ratio, on, lg}, 16'h0000);
    chk({alert, ill, cin, cout, wide, refs, shdn}, 16'h0000);
    rst_b = 1'b1;
    repeat (2) @(negedge clk);
    chk(rd, 16'h1000);
    chk(alert, 16'h0000);
  endtask
  initial begin
    repeat (4) @(negedge clk);
    rst_b = 1'b1;
    chk(rd, 16'h0000);
    @(negedge clk);
    chk(rd, 16'h1000);
    t_walk();
    t_ratio();
    t_roll();
    t_crc();
    t_alert();
    t_reset();
    final_report();
  end
  initial begin
    repeat (3000) @(posedge clk);
    n_errors++;
    final_report();
  end
endmodule
`default_nettype wire

// ===== dv/host_frame_model.sv
// host side frame source for the configuration register
`timescale 1ns/1ps
`default_nettype none
module host_frame_model (
  input  wire logic                  clk_i,
  output var cfg_primary_pkg::frame_type frame_o
);
  initial frame_o = '0;
  // one 16-bit frame, write flag on top, valid for a single cycle
  // crc_ok carries whether the host appended a good CRC
  task automatic send(input logic [15:0] word, input logic crc_ok);
    @(negedge clk_i);
    frame_o = '{valid: 1'b1, crc_ok: crc_ok, word: word};
    @(negedge clk_i);
    frame_o.valid = 1'b0;
    frame_o.word  = ~word;
  endtask
endmodule
`default_nettype wire
